// >>> video_resizer_common_control.sv
/*
 Common control of the video resizer: AHB-Lite register file, input
 path and format select, processing window from sync edges, output
 clamps, per-channel request pacing and circular line interrupts.
 Assumes pixels come from same-clock logic; sync pins are asynchronous.
*/
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module video_resizer_common_control #(
    parameter int PIX_W = 16,
    parameter int CHANS = 2
) (
    // Clock, reset, freeze
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             ce,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic                  hreadyout,
    output logic [31:0]           hrdata,
    output logic                  hresp,
    // Sync pins
    input  wire logic             vertical_sync,
    input  wire logic             horizontal_sync,
    // Pixel sources
    input  wire logic [PIX_W-1:0] pipe_pix,
    input  wire logic             pipe_vld,
    input  wire logic [PIX_W-1:0] if_pix,
    input  wire logic             if_vld,
    // Pixel output
    output logic [PIX_W-1:0]      pix_out,
    output logic                  pix_out_vld,
    // Channel request pacing and line interrupts
    input  wire logic [CHANS-1:0] req_want,
    input  wire logic [CHANS-1:0] line_done,
    output logic [CHANS-1:0]      req_issue,
    output logic [CHANS-1:0]      line_irq,
    output logic [CHANS-1:0]      chan_enable,
    // Mode outputs
    output logic                  gated_core_clock,
    output logic                  rescale,
    output logic                  resizer_bypass,
    output logic                  pass_through,
    output logic                  flip_raw,
    output logic                  chroma_mid,
    output logic                  busy
);
    typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_RDWAIT = 2'b10} bus_st_t;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    bus_st_t     st_q;
    logic [11:0] a_q;
    logic        wr_pend_q;
    logic        rdy_q;
    logic [31:0] rd_q;
    logic [31:0] rd_mux;
    wire         take = hsel & htrans[1] & hready;

    // Reads get one wait state so data always comes from a flop
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q      <= BUS_IDLE;
            a_q       <= 12'h000;
            wr_pend_q <= 1'b0;
            rdy_q     <= 1'b1;
            rd_q      <= 32'h0000_0000;
        end
        else if (ce)
        begin
            wr_pend_q <= take & hwrite;
            if (take)
                a_q <= haddr[11:0];
            if (st_q == BUS_RDWAIT)
            begin
                rd_q  <= rd_mux;
                rdy_q <= 1'b1;
                st_q  <= BUS_IDLE;
            end
            else if (take && !hwrite)
            begin
                rdy_q <= 1'b0;
                st_q  <= BUS_RDWAIT;
            end
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic        start_q, path_q, pass_q, core_q, reg_gate_q, phs_q;
    logic [2:0]  fmt_q;
    logic [15:0] vps_q, hps_q;
    logic [12:0] vsz_q;
    logic [11:0] hsz_hi_q;
    logic [7:0]  ymin_q, ymax_q, cmin_q, cmax_q;
    logic [7:0]  dma_iv_q [CHANS];
    logic [12:0] irq_iv_q [CHANS];
    logic [CHANS-1:0] en_q;
    logic        busy_q;
    wire  [12:0] hsz = {hsz_hi_q, 1'b1};

    // Gate off leaves only the start, gate and enable words writable
    wire exempt = a_q == resizer_ctrl_pkg::OFF_START || a_q == resizer_ctrl_pkg::OFF_GCK_REG
                  || a_q == resizer_ctrl_pkg::OFF_GCK_COR || a_q == resizer_ctrl_pkg::OFF_EN_A
                  || a_q == resizer_ctrl_pkg::OFF_EN_B;
    wire we  = wr_pend_q & (reg_gate_q | exempt);
    wire wg  = wr_pend_q & reg_gate_q;

    // Writes land in the data phase; status word has no write path
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_q <= 1'b0; path_q <= 1'b0; pass_q <= 1'b0; fmt_q <= 3'h0;
            vps_q <= 16'h0000; vsz_q <= 13'h0000; hps_q <= 16'h0000; hsz_hi_q <= 12'h000;
            reg_gate_q <= 1'b0; core_q <= resizer_ctrl_pkg::RST_CORE; phs_q <= 1'b0;
            ymin_q <= resizer_ctrl_pkg::RST_MIN; ymax_q <= resizer_ctrl_pkg::RST_MAX;
            cmin_q <= resizer_ctrl_pkg::RST_MIN; cmax_q <= resizer_ctrl_pkg::RST_MAX;
            en_q <= '0;
            for (int i = 0; i < CHANS; i++)
            begin
                dma_iv_q[i] <= 8'h00;
                irq_iv_q[i] <= resizer_ctrl_pkg::RST_IRQ_IV;
            end
        end
        else if (ce)
        begin
            if (we)
            begin
                unique case (a_q)
                    resizer_ctrl_pkg::OFF_START:   start_q    <= hwdata[0];
                    resizer_ctrl_pkg::OFF_GCK_REG: reg_gate_q <= hwdata[0];
                    resizer_ctrl_pkg::OFF_GCK_COR: core_q     <= hwdata[0];
                    resizer_ctrl_pkg::OFF_EN_A:    en_q[0]    <= hwdata[0];
                    resizer_ctrl_pkg::OFF_EN_B:    en_q[1]    <= hwdata[0];
                    default: ;
                endcase
            end
            if (wg)
            begin
                unique case (a_q)
                    resizer_ctrl_pkg::OFF_PATH:  {pass_q, path_q} <= hwdata[1:0];
                    resizer_ctrl_pkg::OFF_FMT:   fmt_q    <= hwdata[2:0];
                    resizer_ctrl_pkg::OFF_VPS:   vps_q    <= hwdata[15:0];
                    resizer_ctrl_pkg::OFF_VSZ:   vsz_q    <= hwdata[12:0];
                    resizer_ctrl_pkg::OFF_HPS:   hps_q    <= hwdata[15:0];
                    resizer_ctrl_pkg::OFF_HSZ:   hsz_hi_q <= hwdata[12:1];
                    resizer_ctrl_pkg::OFF_DMA_A: dma_iv_q[0] <= hwdata[7:0];
                    resizer_ctrl_pkg::OFF_DMA_B: dma_iv_q[1] <= hwdata[7:0];
                    resizer_ctrl_pkg::OFF_IRQ_A: irq_iv_q[0] <= hwdata[12:0];
                    resizer_ctrl_pkg::OFF_IRQ_B: irq_iv_q[1] <= hwdata[12:0];
                    resizer_ctrl_pkg::OFF_YMIN:  ymin_q   <= hwdata[7:0];
                    resizer_ctrl_pkg::OFF_YMAX:  ymax_q   <= hwdata[7:0];
                    resizer_ctrl_pkg::OFF_CMIN:  cmin_q   <= hwdata[7:0];
                    resizer_ctrl_pkg::OFF_CMAX:  cmax_q   <= hwdata[7:0];
                    resizer_ctrl_pkg::OFF_PHS:   phs_q    <= hwdata[0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux; unmapped words and reserved bits read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (a_q)
            resizer_ctrl_pkg::OFF_START:   rd_mux[0]    = start_q;
            resizer_ctrl_pkg::OFF_PATH:    rd_mux[1:0]  = {pass_q, path_q};
            resizer_ctrl_pkg::OFF_FMT:     rd_mux[2:0]  = fmt_q;
            resizer_ctrl_pkg::OFF_VPS:     rd_mux[15:0] = vps_q;
            resizer_ctrl_pkg::OFF_VSZ:     rd_mux[12:0] = vsz_q;
            resizer_ctrl_pkg::OFF_HPS:     rd_mux[15:0] = hps_q;
            resizer_ctrl_pkg::OFF_HSZ:     rd_mux[12:0] = hsz;
            resizer_ctrl_pkg::OFF_DMA_A:   rd_mux[7:0]  = dma_iv_q[0];
            resizer_ctrl_pkg::OFF_DMA_B:   rd_mux[7:0]  = dma_iv_q[1];
            resizer_ctrl_pkg::OFF_STA:     rd_mux[0]    = busy_q;
            resizer_ctrl_pkg::OFF_GCK_REG: rd_mux[0]    = reg_gate_q;
            resizer_ctrl_pkg::OFF_GCK_COR: rd_mux[0]    = core_q;
            resizer_ctrl_pkg::OFF_IRQ_A:   rd_mux[12:0] = irq_iv_q[0];
            resizer_ctrl_pkg::OFF_IRQ_B:   rd_mux[12:0] = irq_iv_q[1];
            resizer_ctrl_pkg::OFF_YMIN:    rd_mux[7:0]  = ymin_q;
            resizer_ctrl_pkg::OFF_YMAX:    rd_mux[7:0]  = ymax_q;
            resizer_ctrl_pkg::OFF_CMIN:    rd_mux[7:0]  = cmin_q;
            resizer_ctrl_pkg::OFF_CMAX:    rd_mux[7:0]  = cmax_q;
            resizer_ctrl_pkg::OFF_PHS:     rd_mux[0]    = phs_q;
            resizer_ctrl_pkg::OFF_EN_A:    rd_mux[0]    = en_q[0];
            resizer_ctrl_pkg::OFF_EN_B:    rd_mux[0]    = en_q[1];
            default: ;
        endcase
    end

    // ------------------------------------------------------------
    // Sync pin conditioning
    // ------------------------------------------------------------
    logic [2:0] vs_s_q, hs_s_q;
    logic       vs_f_q, hs_f_q, vs_p_q, hs_p_q;

    // Level moves only when stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            vs_s_q <= 3'h0; hs_s_q <= 3'h0;
            vs_f_q <= 1'b0; hs_f_q <= 1'b0; vs_p_q <= 1'b0; hs_p_q <= 1'b0;
        end
        else if (ce)
        begin
            vs_s_q <= {vs_s_q[1:0], vertical_sync};
            hs_s_q <= {hs_s_q[1:0], horizontal_sync};
            if (vs_s_q[1] == vs_s_q[2])
                vs_f_q <= vs_s_q[2];
            if (hs_s_q[1] == hs_s_q[2])
                hs_f_q <= hs_s_q[2];
            vs_p_q <= vs_f_q;
            hs_p_q <= hs_f_q;
        end
    end
    wire vs_rise = vs_f_q & ~vs_p_q;
    wire hs_rise = hs_f_q & ~hs_p_q;

    // ------------------------------------------------------------
    // Processing window
    // ------------------------------------------------------------
    logic [15:0] line_q, col_q;
    wire [PIX_W-1:0] src_pix = path_q ? if_pix : pipe_pix;
    wire         src_vld = path_q ? if_vld : pipe_vld;
    wire [15:0]  v_off   = line_q - vps_q;
    wire [15:0]  h_off   = col_q - hps_q;
    wire         in_v    = line_q >= vps_q && v_off <= {3'h0, vsz_q};
    wire         in_h    = col_q >= hps_q && h_off <= {3'h0, hsz};
    wire         last_px = in_v && v_off == {3'h0, vsz_q} && h_off == {3'h0, hsz} && in_h;
    wire         win     = busy_q & in_v & in_h & src_vld;

    // Line count restarts on vertical sync so first line is zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_q <= 16'hffff; col_q <= 16'h0000; busy_q <= 1'b0;
        end
        else if (ce)
        begin
            if (vs_rise)
                line_q <= 16'hffff;
            else if (hs_rise)
                line_q <= line_q + 16'h0001;
            if (hs_rise)
                col_q <= 16'h0000;
            else if (src_vld && col_q != 16'hffff)
                col_q <= col_q + 16'h0001;
            if (vs_rise)
                busy_q <= start_q;
            else if (win && last_px)
                busy_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Output format and clamps
    // ------------------------------------------------------------
    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
        clamp8 = v < lo ? lo : (v > hi ? hi : v);
    endfunction
    // 4:2:2 carries C high and Y low; 4:2:0 carries one component in both
    wire hi_c = !fmt_q[resizer_ctrl_pkg::BIT_FMT_420] || fmt_q[resizer_ctrl_pkg::BIT_FMT_COL];
    wire lo_c = fmt_q[resizer_ctrl_pkg::BIT_FMT_420] && fmt_q[resizer_ctrl_pkg::BIT_FMT_COL];
    wire [7:0] hi_in = src_pix[15:8];
    wire [7:0] lo_in = src_pix[7:0];
    wire [7:0] hi_cl = hi_c ? clamp8(hi_in, cmin_q, cmax_q) : clamp8(hi_in, ymin_q, ymax_q);
    wire [7:0] lo_cl = lo_c ? clamp8(lo_in, cmin_q, cmax_q) : clamp8(lo_in, ymin_q, ymax_q);
    logic [PIX_W-1:0] pix_q;
    logic pix_vld_q, resc_q, rbyp_q, pth_q;

    // Pass-through sends raw samples untouched
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pix_q <= '0; pix_vld_q <= 1'b0;
            resc_q <= 1'b0; rbyp_q <= 1'b0; pth_q <= 1'b0;
        end
        else if (ce)
        begin
            pix_vld_q <= win;
            if (win)
                pix_q <= pass_q ? src_pix : {hi_cl, lo_cl};
            resc_q <= core_q & ~pass_q;
            rbyp_q <= ~core_q & ~pass_q;
            pth_q  <= pass_q;
        end
    end

    // ------------------------------------------------------------
    // Per-channel pacing and circular line interrupt
    // ------------------------------------------------------------
    logic [7:0]  gap_q [CHANS];
    logic [12:0] lc_q  [CHANS];
    logic [CHANS-1:0] iss_q, irq_q;
    genvar g;
    generate
        for (g = 0; g < CHANS; g++)
        begin : g_ch
            // Gap loads interval minus one so issues sit interval edges apart
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    gap_q[g] <= 8'h00; lc_q[g] <= 13'h0000;
                    iss_q[g] <= 1'b0;  irq_q[g] <= 1'b0;
                end
                else if (ce)
                begin
                    iss_q[g] <= req_want[g] && en_q[g] && gap_q[g] == 8'h00;
                    if (req_want[g] && en_q[g] && gap_q[g] == 8'h00)
                        gap_q[g] <= dma_iv_q[g] == 8'h00 ? 8'h00 : dma_iv_q[g] - 8'h01;
                    else if (gap_q[g] != 8'h00)
                        gap_q[g] <= gap_q[g] - 8'h01;
                    irq_q[g] <= en_q[g] && line_done[g] && lc_q[g] == irq_iv_q[g];
                    if (vs_rise)
                        lc_q[g] <= 13'h0000;
                    else if (en_q[g] && line_done[g])
                        lc_q[g] <= lc_q[g] == irq_iv_q[g] ? 13'h0000 : lc_q[g] + 13'h0001;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout        = rdy_q;
    assign hrdata           = rd_q;
    assign hresp            = 1'b0;
    assign pix_out          = pix_q;
    assign pix_out_vld      = pix_vld_q;
    assign req_issue        = iss_q;
    assign line_irq         = irq_q;
    assign chan_enable      = en_q;
    assign gated_core_clock = core_q;
    assign rescale          = resc_q;
    assign resizer_bypass   = rbyp_q;
    assign pass_through     = pth_q;
    assign flip_raw         = fmt_q[resizer_ctrl_pkg::BIT_FMT_RAW];
    assign chroma_mid       = phs_q;
    assign busy             = busy_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] since_a_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            since_a_q <= 8'hff;
        else if (ce)
            since_a_q <= iss_q[0] ? 8'h01 : (since_a_q == 8'hff ? 8'hff : since_a_q + 8'h01);
    end
    chk_gate_blocks_write: assert property (wr_pend_q && ce && !reg_gate_q && a_q == resizer_ctrl_pkg::OFF_YMAX |=> $stable(ymax_q)) else $error("gated write landed");
    chk_pace_a_spacing: assert property (iss_q[0] && since_a_q != 8'hff |-> since_a_q >= dma_iv_q[0]) else $error("channel a requests too close");
    chk_status_read: assert property (st_q == BUS_RDWAIT && ce && a_q == resizer_ctrl_pkg::OFF_STA |=> rd_q == {31'h0, $past(busy_q)}) else $error("status read wrong");
    chk_mode_onehot: assert property ($past(ce) |-> $onehot0({resc_q, rbyp_q, pth_q})) else $error("modes overlap");
    chk_core_off_bypass: assert property (resc_q |-> $past(core_q) || !$past(ce)) else $error("rescale with core off");
    chk_window_rows: assert property (pix_vld_q |-> $past(in_v) && $past(busy_q)) else $error("pixel outside rows");
    chk_window_cols: assert property (pix_vld_q |-> $past(in_h)) else $error("pixel outside columns");
    chk_path_valid: assert property (pix_vld_q |-> $past(path_q ? if_vld : pipe_vld)) else $error("wrong source");
    chk_luma_low: assert property (pix_vld_q && !pth_q && !$past(fmt_q[1]) && $past(ymin_q <= ymax_q) |-> pix_q[7:0] >= $past(ymin_q) && pix_q[7:0] <= $past(ymax_q)) else $error("luma out of range");
    chk_chroma_range: assert property (pix_vld_q && !pth_q && !$past(fmt_q[1]) && $past(cmin_q <= cmax_q) |-> pix_q[15:8] >= $past(cmin_q) && pix_q[15:8] <= $past(cmax_q)) else $error("chroma out of range");
    chk_irq_interval: assert property (irq_q[0] |-> $past(line_done[0] && lc_q[0] == irq_iv_q[0])) else $error("irq off count");
endmodule

// >>> resizer_ctrl_pkg.sv
/*
 Constants of the resizer common control block: register offsets,
 field positions, reset values and widths.
 Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
*/
package resizer_ctrl_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_START   = 12'h000;
    localparam logic [11:0] OFF_PATH    = 12'h008;
    localparam logic [11:0] OFF_FMT     = 12'h00c;
    localparam logic [11:0] OFF_VPS     = 12'h010;
    localparam logic [11:0] OFF_VSZ     = 12'h014;
    localparam logic [11:0] OFF_HPS     = 12'h018;
    localparam logic [11:0] OFF_HSZ     = 12'h01c;
    localparam logic [11:0] OFF_DMA_A   = 12'h020;
    localparam logic [11:0] OFF_DMA_B   = 12'h024;
    localparam logic [11:0] OFF_STA     = 12'h028;
    localparam logic [11:0] OFF_GCK_REG = 12'h02c;
    localparam logic [11:0] OFF_GCK_COR = 12'h030;
    localparam logic [11:0] OFF_IRQ_A   = 12'h034;
    localparam logic [11:0] OFF_IRQ_B   = 12'h038;
    localparam logic [11:0] OFF_YMIN    = 12'h03c;
    localparam logic [11:0] OFF_YMAX    = 12'h040;
    localparam logic [11:0] OFF_CMIN    = 12'h044;
    localparam logic [11:0] OFF_CMAX    = 12'h048;
    localparam logic [11:0] OFF_PHS     = 12'h04c;
    localparam logic [11:0] OFF_EN_A    = 12'h058;
    localparam logic [11:0] OFF_EN_B    = 12'h0e8;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_PATH_SRC  = 0;
    localparam int BIT_PATH_PASS = 1;
    localparam int BIT_FMT_RAW   = 0;
    localparam int BIT_FMT_420   = 1;
    localparam int BIT_FMT_COL   = 2;
    localparam int POS_WIDTH     = 16;
    localparam int SIZE_WIDTH    = 13;
    localparam int BYTE_WIDTH    = 8;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [12:0] RST_IRQ_IV = 13'h1fff;
    localparam logic [7:0]  RST_MAX    = 8'hff;
    localparam logic [7:0]  RST_MIN    = 8'h00;
    localparam logic        RST_CORE   = 1'b0;
endpackage

// >>> pix_src.sv
/*
 Pixel source model: sync pins and two pixel streams.
 Assumes the bench calls send_frame from its main sequence.
*/
`timescale 1ns/100ps
module pix_src (
    // Clock
    input  wire logic        hclk,
    // Sync and pixels
    output logic             vsync,
    output logic             hsync,
    output logic [15:0]      pipe_pix,
    output logic             pipe_vld,
    output logic [15:0]      if_pix,
    output logic             if_vld
);
    int n_req = 0, n_sent = 0;
    // Idle data toggles so a stale pixel is never taken for a new one;
    // only the task raises n_req, so no two processes race on one count
    always @(posedge hclk)
    begin
        pipe_vld <= n_sent < n_req;
        if_vld   <= n_sent < n_req;
        pipe_pix <= (n_sent < n_req) ? 16'h5555 : ~pipe_pix;
        if_pix   <= (n_sent < n_req) ? 16'h10f0 : ~if_pix;
        n_sent   <= (n_sent < n_req) ? n_sent + 1 : n_sent;
    end
    // One frame: sync pulses longer than the input filter, then pixels
    task send_frame;
        vsync <= 1'b1;
        repeat (8) @(posedge hclk);
        vsync <= 1'b0;
        hsync <= 1'b1;
        repeat (8) @(posedge hclk);
        hsync <= 1'b0;
        repeat (8) @(posedge hclk);
        n_req <= n_req + 4;
    endtask
    initial
    begin
        {vsync, hsync, pipe_vld, if_vld} = 4'h0;
        pipe_pix = 16'h0ff0;
        if_pix   = 16'hf00f;
    end
endmodule

// >>> video_resizer_common_control_tb_top.sv
/*
 Bench of the resizer control: AHB-Lite tasks, clamps, pacing, line
 interrupts and modes. Assumes one 200 MHz clock and one slave.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module video_resizer_common_control_tb_top;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'b00, req_want = 2'b00, line_done = 2'b00, req_issue, line_irq, chan_enable;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [15:0] pipe_pix, if_pix, pix_out, last_pix;
    logic        hreadyout, vsync, hsync, pipe_vld, if_vld, pix_out_vld, hresp, busy, flip_raw, chroma_mid;
    logic        gated_core_clock, rescale, resizer_bypass, pass_through;
    int          fail_count = 0, n_compared = 0, npix = 0;
    pix_src src_u (.hclk(hclk), .vsync(vsync), .hsync(hsync), .pipe_pix(pipe_pix),
        .pipe_vld(pipe_vld), .if_pix(if_pix), .if_vld(if_vld));
    video_resizer_common_control dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .vertical_sync(vsync), .horizontal_sync(hsync), .pipe_pix(pipe_pix),
        .pipe_vld(pipe_vld), .if_pix(if_pix), .if_vld(if_vld), .pix_out(pix_out),
        .pix_out_vld(pix_out_vld), .req_want(req_want), .line_done(line_done),
        .req_issue(req_issue), .line_irq(line_irq), .chan_enable(chan_enable),
        .gated_core_clock(gated_core_clock), .rescale(rescale), .resizer_bypass(resizer_bypass),
        .pass_through(pass_through), .flip_raw(flip_raw), .chroma_mid(chroma_mid), .busy(busy));
    initial forever #2.5 hclk = ~hclk;
    // ------------------------------------------------------------
    // Bus, pacing and interrupt tasks
    // ------------------------------------------------------------
    // Single word transfer; read data taken at the edge that ends it
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 20'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        {hsel, htrans} <= 3'b000;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK({hresp, rd}, {1'b0, e})
    endtask
    // Edges between two issued requests of one channel
    task pace(input int ch, input int e);
        int n;
        n = 1;
        @(posedge hclk);
        while (req_issue[ch] !== 1'b1) @(posedge hclk);
        @(posedge hclk);
        while (req_issue[ch] !== 1'b1)
        begin
            @(posedge hclk);
            n++;
        end
        `CHK(n, e)
    endtask
    // Interrupt must follow only the last of v plus one lines
    task irq(input int ch, input int v);
        for (int k = 0; k <= v; k++)
        begin
            @(posedge hclk);
            line_done[ch] <= 1'b1;
            @(posedge hclk);
            line_done[ch] <= 1'b0;
            @(posedge hclk);
            `CHK(line_irq[ch], 1'(k == v))
        end
    endtask
    task give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Pre-edge sampling keeps the count free of races
    always @(posedge hclk)
    begin
        if (pix_out_vld === 1'b1) npix++;
        if (pix_out_vld === 1'b1) last_pix <= pix_out;
    end
    initial
    begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        give_verdict();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(resizer_ctrl_pkg::OFF_HSZ, 32'h1);
        rchk(resizer_ctrl_pkg::OFF_IRQ_B, 32'h1fff);
        rchk(resizer_ctrl_pkg::OFF_CMAX, 32'hff);
        xfer(1'b1, resizer_ctrl_pkg::OFF_YMAX, 32'h80);
        rchk(resizer_ctrl_pkg::OFF_YMAX, 32'hff);
        xfer(1'b1, resizer_ctrl_pkg::OFF_GCK_REG, 32'h1);
        xfer(1'b1, resizer_ctrl_pkg::OFF_YMAX, 32'h80);
        xfer(1'b1, resizer_ctrl_pkg::OFF_CMIN, 32'h20);
        xfer(1'b1, resizer_ctrl_pkg::OFF_HSZ, 32'h10);
        rchk(resizer_ctrl_pkg::OFF_HSZ, 32'h11);
        xfer(1'b1, resizer_ctrl_pkg::OFF_HSZ, 32'h0);
        xfer(1'b1, resizer_ctrl_pkg::OFF_STA, 32'h1);
        rchk(resizer_ctrl_pkg::OFF_STA, 32'h0);
        rchk(12'h0fc, 32'h0);
        $display("registers done");
        xfer(1'b1, resizer_ctrl_pkg::OFF_PATH, 32'h1);
        xfer(1'b1, resizer_ctrl_pkg::OFF_START, 32'h1);
        src_u.send_frame();
        `CHK(busy, 1'b1)
        repeat (20) @(posedge hclk);
        `CHK(npix, 2)
        `CHK(last_pix, 16'h2080)
        rchk(resizer_ctrl_pkg::OFF_STA, 32'h0);
        $display("frame done");
        xfer(1'b1, resizer_ctrl_pkg::OFF_DMA_A, 32'h4);
        xfer(1'b1, resizer_ctrl_pkg::OFF_DMA_B, 32'h7);
        xfer(1'b1, resizer_ctrl_pkg::OFF_EN_A, 32'h1);
        xfer(1'b1, resizer_ctrl_pkg::OFF_EN_B, 32'h1);
        req_want <= 2'b11;
        pace(0, 4);
        pace(1, 7);
        `CHK(chan_enable, 2'b11)
        req_want <= 2'b00;
        xfer(1'b1, resizer_ctrl_pkg::OFF_IRQ_A, 32'h1);
        xfer(1'b1, resizer_ctrl_pkg::OFF_IRQ_B, 32'h2);
        irq(0, 1);
        irq(1, 2);
        $display("pacing and interrupts done");
        for (int i = 0; i < 3; i++)
        begin
            xfer(1'b1, resizer_ctrl_pkg::OFF_GCK_COR, {31'h0, i == 0});
            xfer(1'b1, resizer_ctrl_pkg::OFF_PATH, {30'h0, i == 2, 1'b1});
            repeat (2) @(posedge hclk);
            `CHK({gated_core_clock, rescale, resizer_bypass, pass_through}, i == 0 ? 4'hc : i == 1 ? 4'h2 : 4'h1)
        end
        $display("modes done");
        // Raw flip order, mid chroma, then a pass-through and a 4:2:0 chroma frame
        xfer(1'b1, resizer_ctrl_pkg::OFF_FMT, 32'h7);
        xfer(1'b1, resizer_ctrl_pkg::OFF_PHS, 32'h1);
        @(posedge hclk);
        `CHK(flip_raw, 1'b1)
        `CHK(chroma_mid, 1'b1)
        src_u.send_frame();
        repeat (20) @(posedge hclk);
        `CHK(last_pix, 16'h10f0)
        xfer(1'b1, resizer_ctrl_pkg::OFF_PATH, 32'h1);
        src_u.send_frame();
        repeat (20) @(posedge hclk);
        `CHK(last_pix, 16'h20f0)
        `CHK(npix, 6)
        $display("format frames done");
        give_verdict();
    end
endmodule
